// ===== pkg/dapsel_defs.svh
// Purpose: Offsets, field positions and reset values of the port selector
// Assumes: Byte offsets within one access port's 256-byte register space
// Notes: Definitions only; included by bare name
`ifndef DAPSEL_DEFS_SVH
`define DAPSEL_DEFS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define DAPSEL_OFF_IDENT 8'hFC
`define DAPSEL_OFF_CTRL 8'h00
`define DAPSEL_OFF_ADDR 8'h04
`define DAPSEL_OFF_DATA 8'h0C
`define DAPSEL_OFF_CFG 8'hF4
`define DAPSEL_OFF_BASE 8'hF8
`define DAPSEL_BANKED_BANK 4'h1

// ****************************************************************
// Field positions and reset values
// ****************************************************************
`define DAPSEL_BANK_LSB 4
`define DAPSEL_SLOT_LSB 2
`define DAPSEL_BLOCK_LSB 12
`define DAPSEL_RST_CTRL 32'h0000_0000
`define DAPSEL_RST_ADDR 32'h0000_0000
`define DAPSEL_RST_DATA 32'h0000_0000

`endif

// ===== pkg/dapsel_pkg.sv
// Purpose: Types shared by the port selector modules
// Assumes: Eight-bit port number, four-bit bank, two-bit slot
// Notes: No constants live here; see dapsel_defs.svh
`default_nettype none
package dapsel_pkg;

    typedef logic [7:0] dapsel_port_t;

    // One-hot front-end sequencer states
    typedef enum logic [3:0] {
        DAPSEL_ST_IDLE = 4'b0001,
        DAPSEL_ST_DISPATCH = 4'b0010,
        DAPSEL_ST_WAIT_MEM = 4'b0100,
        DAPSEL_ST_WAIT_EXT = 4'b1000
    } dapsel_state_e;

    // Where a request lands once decoded
    typedef enum logic [4:0] {
        DAPSEL_TGT_IDENT = 5'b00001,
        DAPSEL_TGT_RESERVED = 5'b00010,
        DAPSEL_TGT_MEMREG = 5'b00100,
        DAPSEL_TGT_MEMXFER = 5'b01000,
        DAPSEL_TGT_EXT = 5'b10000
    } dapsel_target_e;

    typedef struct packed {
        dapsel_port_t port;
        logic [3:0] bank;
        logic [1:0] slot;
        logic read_not_write;
        logic [31:0] wdata;
    } dapsel_req_s;

endpackage
`default_nettype wire

// ===== pkg/dapsel_link_if.sv
// Purpose: Carries requests between the front end, decoder and engine
// Assumes: All parties on one clock
// Notes: No clocking block; plain signals
`timescale 1ns/100ps
`default_nettype none
interface dapsel_link_if;
    dapsel_pkg::dapsel_req_s req;
    dapsel_pkg::dapsel_target_e target;
    logic start;
    logic [31:0] xfer_addr;
    logic xfer_done;
    logic [31:0] xfer_rdata;

    modport front (output req, output start, output xfer_addr,
        input target, input xfer_done, input xfer_rdata);
    modport dec (input req, output target);
    modport eng (input req, input start, input xfer_addr,
        output xfer_done, output xfer_rdata);
endinterface
`default_nettype wire

// ===== logic/dapsel_decode.sv
// Purpose: Classifies a held request by port and register offset
// Assumes: Request fields stable while the front end dispatches
// Notes: Purely combinational
`timescale 1ns/100ps
`default_nettype none
`include "dapsel_defs.svh"
module dapsel_decode #(
    parameter int NUM_PORTS = 2,
    parameter int MEM_PORT = 0
) (
    dapsel_link_if.dec link
);
    logic [7:0] offset;

    // ****************************************************************
    // Target classification
    // ****************************************************************
    // Identity check comes first so every port answers at the top slot
    always_comb begin
        offset = {link.req.bank, link.req.slot, 2'b00};
        if (offset == `DAPSEL_OFF_IDENT) begin
            link.target = dapsel_pkg::DAPSEL_TGT_IDENT;
        end else if (32'(link.req.port) >= NUM_PORTS) begin
            link.target = dapsel_pkg::DAPSEL_TGT_RESERVED;
        end else if (32'(link.req.port) == MEM_PORT) begin
            // Local registers never start a memory transfer
            if (offset == `DAPSEL_OFF_CTRL || offset == `DAPSEL_OFF_ADDR ||
                    offset == `DAPSEL_OFF_CFG ||
                    offset == `DAPSEL_OFF_BASE) begin
                link.target = dapsel_pkg::DAPSEL_TGT_MEMREG;
            end else if (offset == `DAPSEL_OFF_DATA ||
                    link.req.bank == `DAPSEL_BANKED_BANK) begin
                link.target = dapsel_pkg::DAPSEL_TGT_MEMXFER;
            end else begin
                link.target = dapsel_pkg::DAPSEL_TGT_RESERVED;
            end
        end else begin
            link.target = dapsel_pkg::DAPSEL_TGT_EXT;
        end
    end
endmodule
`default_nettype wire

// ===== logic/dapsel_mem_xfer.sv
// Purpose: Runs one memory-side transfer per start pulse
// Assumes: Memory side answers with a one-cycle done, same clock
// Notes: No time limit on the wait; slow memories simply stall
`timescale 1ns/100ps
`default_nettype none
`include "dapsel_defs.svh"
module dapsel_mem_xfer (
    input wire logic sys_clk_in,
    input wire logic arst_n_in,
    dapsel_link_if.eng link,
    output logic mem_req_out,
    output logic mem_write_out,
    output logic [31:0] mem_addr_out,
    output logic [31:0] mem_wdata_out,
    input wire logic mem_done_in,
    input wire logic [31:0] mem_rdata_in
);
    logic req_d, req_q, wr_d, wr_q, done_d, done_q;
    logic [31:0] addr_d, addr_q, wdata_d, wdata_q, rdata_d, rdata_q;

    // ****************************************************************
    // Transfer handshake
    // ****************************************************************
    // Request level holds until the memory side reports completion
    always_comb begin
        req_d = req_q;
        wr_d = wr_q;
        addr_d = addr_q;
        wdata_d = wdata_q;
        rdata_d = rdata_q;
        done_d = 1'b0;
        if (!req_q && link.start) begin
            req_d = 1'b1;
            wr_d = !link.req.read_not_write;
            addr_d = link.xfer_addr;
            wdata_d = link.req.wdata;
        end else if (req_q && mem_done_in) begin
            req_d = 1'b0;
            done_d = 1'b1;
            rdata_d = mem_rdata_in;
        end
    end

    // Register stage
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            req_q <= 1'b0;
            wr_q <= 1'b0;
            done_q <= 1'b0;
            addr_q <= `DAPSEL_RST_DATA;
            wdata_q <= `DAPSEL_RST_DATA;
            rdata_q <= `DAPSEL_RST_DATA;
        end else begin
            req_q <= req_d;
            wr_q <= wr_d;
            done_q <= done_d;
            addr_q <= addr_d;
            wdata_q <= wdata_d;
            rdata_q <= rdata_d;
        end
    end

    assign mem_req_out = req_q;
    assign mem_write_out = wr_q;
    assign mem_addr_out = addr_q;
    assign mem_wdata_out = wdata_q;
    assign link.xfer_done = done_q;
    assign link.xfer_rdata = rdata_q;
endmodule
`default_nettype wire

// ===== logic/dapsel_top.sv
// Purpose: Access-port front end: selects port, bank and slot per request
// Assumes: Request side and downstream ports share sys_clk_in
// Notes: One request at a time; busy_out stalls the debug port
//
// Function
// - Every port answers its identification at byte offset 0xFC.
// - Port select value at request time picks the target port.
// - Select bank number forms address bits 7:4 of the access.
// - Request address bits 3:2 pick one of four bank registers.
// - Request direction bit chooses read or write.
// - A request may stay pending for any number of cycles.
// - Downstream-dependent requests finish only after downstream completes.
// - Memory port local register accesses make no memory transfer.
// - Component debug registers sit in aligned 4KB blocks.
// - Several components behind memory port need a component table.
// - Data and bank register requests to the memory port reach the attached components.
// - Reserved addresses read zero and ignore writes.
// - Requests without memory or external-port transfer complete at once.
`timescale 1ns/100ps
`default_nettype none
`include "dapsel_defs.svh"
module dapsel_top #(
    parameter int NUM_PORTS = 2,
    parameter int MEM_PORT = 0,
    // Arbitrary identification values, one word per port, port 0 lowest
    parameter logic [NUM_PORTS*32-1:0] PORT_IDENTS = {
        32'h1234_0002, 32'h1234_0001},
    parameter logic [31:0] CFG_VALUE = 32'h0000_0000,
    parameter logic [31:0] BASE_ADDR = 32'h0000_0000,
    parameter int NUM_COMPONENTS = 1,
    parameter bit HAS_TABLE = 1'b0
) (
    input wire logic sys_clk_in,
    input wire logic arst_n_in,
    input wire logic req_valid_in,
    input wire logic req_read_not_write_in,
    input wire logic [1:0] req_addr_in,
    input wire logic [31:0] req_wdata_in,
    input wire logic [7:0] sel_port_in,
    input wire logic [3:0] sel_bank_in,
    output logic busy_out,
    output logic done_out,
    output logic [31:0] rdata_out,
    output logic mem_req_out,
    output logic mem_write_out,
    output logic [31:0] mem_addr_out,
    output logic [31:0] mem_wdata_out,
    input wire logic mem_done_in,
    input wire logic [31:0] mem_rdata_in,
    output logic ext_req_out,
    output logic ext_write_out,
    output logic [7:0] ext_port_out,
    output logic [5:0] ext_addr_out,
    output logic [31:0] ext_wdata_out,
    input wire logic ext_done_in,
    input wire logic [31:0] ext_rdata_in
);

    // ****************************************************************
    // Elaboration checks
    // ****************************************************************
    if (NUM_PORTS < 1 || NUM_PORTS > 256) begin : g_bad_ports
        $error("NUM_PORTS must lie in 1..256");
    end
    if (MEM_PORT < 0 || MEM_PORT >= NUM_PORTS) begin : g_bad_mem
        $error("MEM_PORT must name an existing port");
    end
    // A system with several components must point at a component table
    if (NUM_COMPONENTS > 1 && !HAS_TABLE) begin : g_bad_table
        $error("Several components need a component table");
    end
    // Base must start a 4KB block
    if (BASE_ADDR[`DAPSEL_BLOCK_LSB-1:0] != '0) begin : g_bad_base
        $error("BASE_ADDR must be 4KB aligned");
    end

    // ****************************************************************
    // Helpers
    // ****************************************************************
    // Identification word of a port; ports beyond the table read zero
    function automatic logic [31:0] ident_of(input logic [7:0] port);
        logic [31:0] val;
        val = 32'h0000_0000;
        for (int i = 0; i < NUM_PORTS; i++) begin
            if (port == 8'(i)) begin
                val = PORT_IDENTS[i*32 +: 32];
            end
        end
        return val;
    endfunction

    // Offset of a request within its port's register space
    function automatic logic [7:0] offset_of(
            input dapsel_pkg::dapsel_req_s r);
        return {r.bank, r.slot, 2'b00};
    endfunction

    // ****************************************************************
    // Shared link and submodules
    // ****************************************************************
    dapsel_link_if link ();

    dapsel_decode #(
        .NUM_PORTS(NUM_PORTS),
        .MEM_PORT(MEM_PORT)
    ) u_decode (
        .link(link)
    );

    dapsel_mem_xfer u_xfer (
        .sys_clk_in(sys_clk_in),
        .arst_n_in(arst_n_in),
        .link(link),
        .mem_req_out(mem_req_out),
        .mem_write_out(mem_write_out),
        .mem_addr_out(mem_addr_out),
        .mem_wdata_out(mem_wdata_out),
        .mem_done_in(mem_done_in),
        .mem_rdata_in(mem_rdata_in)
    );

    // ****************************************************************
    // State
    // ****************************************************************
    dapsel_pkg::dapsel_state_e st_d, st_q;
    dapsel_pkg::dapsel_req_s req_d, req_q;
    logic busy_d, busy_q;
    logic done_d, done_q;
    logic start_d, start_q;
    logic ext_req_d, ext_req_q;
    logic [31:0] rdata_d, rdata_q;
    logic [31:0] ctrl_d, ctrl_q;
    logic [31:0] addr_d, addr_q;

    // Held request drives decoder and engine
    assign link.req = req_q;
    assign link.start = start_q;
    // Data slot uses the address as is; banked slots replace bits 3:2 with the slot and clear bits 1:0
    assign link.xfer_addr = (req_q.bank == `DAPSEL_BANKED_BANK) ?
        {addr_q[31:4], req_q.slot, 2'b00} : addr_q;

    // ****************************************************************
    // Sequencer next state
    // ****************************************************************
    // Requests are taken only in idle; busy keeps the debug port waiting
    always_comb begin
        st_d = st_q;
        req_d = req_q;
        busy_d = busy_q;
        done_d = 1'b0;
        start_d = 1'b0;
        ext_req_d = ext_req_q;
        rdata_d = rdata_q;
        ctrl_d = ctrl_q;
        addr_d = addr_q;
        unique case (st_q)
            dapsel_pkg::DAPSEL_ST_IDLE: begin
                if (req_valid_in) begin
                    req_d.port = sel_port_in;
                    req_d.bank = sel_bank_in;
                    req_d.slot = req_addr_in;
                    req_d.read_not_write = req_read_not_write_in;
                    req_d.wdata = req_wdata_in;
                    busy_d = 1'b1;
                    st_d = dapsel_pkg::DAPSEL_ST_DISPATCH;
                end
            end
            dapsel_pkg::DAPSEL_ST_DISPATCH: begin
                unique case (link.target)
                    dapsel_pkg::DAPSEL_TGT_IDENT: begin
                        // Read-only; a write leaves the data as it was
                        if (req_q.read_not_write) begin
                            rdata_d = ident_of(req_q.port);
                        end
                        done_d = 1'b1;
                        busy_d = 1'b0;
                        st_d = dapsel_pkg::DAPSEL_ST_IDLE;
                    end
                    dapsel_pkg::DAPSEL_TGT_RESERVED: begin
                        if (req_q.read_not_write) begin
                            rdata_d = 32'h0000_0000;
                        end
                        done_d = 1'b1;
                        busy_d = 1'b0;
                        st_d = dapsel_pkg::DAPSEL_ST_IDLE;
                    end
                    dapsel_pkg::DAPSEL_TGT_MEMREG: begin
                        // No memory request here, only local storage
                        if (req_q.read_not_write) begin
                            unique case (offset_of(req_q))
                                `DAPSEL_OFF_CTRL: rdata_d = ctrl_q;
                                `DAPSEL_OFF_ADDR: rdata_d = addr_q;
                                `DAPSEL_OFF_CFG: rdata_d = CFG_VALUE;
                                default: rdata_d = BASE_ADDR;
                            endcase
                        end else if (offset_of(req_q) ==
                                `DAPSEL_OFF_CTRL) begin
                            ctrl_d = req_q.wdata;
                        end else if (offset_of(req_q) ==
                                `DAPSEL_OFF_ADDR) begin
                            addr_d = req_q.wdata;
                        end
                        done_d = 1'b1;
                        busy_d = 1'b0;
                        st_d = dapsel_pkg::DAPSEL_ST_IDLE;
                    end
                    dapsel_pkg::DAPSEL_TGT_MEMXFER: begin
                        start_d = 1'b1;
                        st_d = dapsel_pkg::DAPSEL_ST_WAIT_MEM;
                    end
                    dapsel_pkg::DAPSEL_TGT_EXT: begin
                        ext_req_d = 1'b1;
                        st_d = dapsel_pkg::DAPSEL_ST_WAIT_EXT;
                    end
                endcase
            end
            dapsel_pkg::DAPSEL_ST_WAIT_MEM: begin
                // No timeout: a slow memory just lengthens the stall
                if (link.xfer_done) begin
                    if (req_q.read_not_write) begin
                        rdata_d = link.xfer_rdata;
                    end
                    done_d = 1'b1;
                    busy_d = 1'b0;
                    st_d = dapsel_pkg::DAPSEL_ST_IDLE;
                end
            end
            dapsel_pkg::DAPSEL_ST_WAIT_EXT: begin
                // A long scan chain may hold this state indefinitely
                if (ext_done_in) begin
                    if (req_q.read_not_write) begin
                        rdata_d = ext_rdata_in;
                    end
                    ext_req_d = 1'b0;
                    done_d = 1'b1;
                    busy_d = 1'b0;
                    st_d = dapsel_pkg::DAPSEL_ST_IDLE;
                end
            end
        endcase
    end

    // ****************************************************************
    // Sequencer registers
    // ****************************************************************
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            st_q <= dapsel_pkg::DAPSEL_ST_IDLE;
            req_q <= '0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
            start_q <= 1'b0;
            ext_req_q <= 1'b0;
            rdata_q <= `DAPSEL_RST_DATA;
            ctrl_q <= `DAPSEL_RST_CTRL;
            addr_q <= `DAPSEL_RST_ADDR;
        end else begin
            st_q <= st_d;
            req_q <= req_d;
            busy_q <= busy_d;
            done_q <= done_d;
            start_q <= start_d;
            ext_req_q <= ext_req_d;
            rdata_q <= rdata_d;
            ctrl_q <= ctrl_d;
            addr_q <= addr_d;
        end
    end

    // ****************************************************************
    // Outputs, all from flops
    // ****************************************************************
    assign busy_out = busy_q;
    assign done_out = done_q;
    assign rdata_out = rdata_q;
    // Downstream port fields hold steady for the whole pending request
    assign ext_req_out = ext_req_q;
    assign ext_write_out = !req_q.read_not_write;
    assign ext_port_out = req_q.port;
    assign ext_addr_out = {req_q.bank, req_q.slot};
    assign ext_wdata_out = req_q.wdata;

endmodule
`default_nettype wire

// ===== verif/dapsel_props.sv
// Purpose: Port-level checks of the access-port selector
// Assumes: One clock domain, asynchronous active-low reset
// Notes: Bound to dapsel_top at the foot of this file
`timescale 1ns/100ps
`default_nettype none
module dapsel_props #(
    parameter int NUM_PORTS = 2,
    parameter int MEM_PORT = 0
) (
    input wire logic sys_clk_in,
    input wire logic arst_n_in,
    input wire logic req_valid_in,
    input wire logic req_read_not_write_in,
    input wire logic [1:0] req_addr_in,
    input wire logic [7:0] sel_port_in,
    input wire logic [3:0] sel_bank_in,
    input wire logic busy_out,
    input wire logic done_out,
    input wire logic mem_req_out,
    input wire logic mem_done_in,
    input wire logic ext_req_out,
    input wire logic ext_done_in,
    input wire logic ext_write_out,
    input wire logic [7:0] ext_port_out,
    input wire logic [5:0] ext_addr_out
);
    // ******
    // Request sequences
    // ******
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!arst_n_in);
    sequence s_take;
        req_valid_in && !busy_out;
    endsequence
    // Local answer: one busy cycle, then the done pulse
    sequence s_quick;
        busy_out && !done_out ##1 done_out && !busy_out;
    endsequence
    sequence s_ident;
        s_take ##0 (sel_bank_in == 4'hF && req_addr_in == 2'h3);
    endsequence
    // Bank 0 slots 0 and 1 of the memory port are plain registers
    sequence s_local;
        s_take ##0 (int'(sel_port_in) == MEM_PORT && sel_bank_in == 4'h0
            && !req_addr_in[1]);
    endsequence
    sequence s_ext;
        s_take ##0 (int'(sel_port_in) != MEM_PORT
            && int'(sel_port_in) < NUM_PORTS
            && !(sel_bank_in == 4'hF && req_addr_in == 2'h3));
    endsequence
    // ******
    // Assertions
    // ******
    a_take_busy: assert property (s_take |=> busy_out && !done_out)
        else $error("no busy after take");
    a_ident_quick: assert property (s_ident |=> s_quick)
        else $error("ident answer late");
    a_local_nomem: assert property (s_local |=> s_quick
        and !mem_req_out[*2]) else $error("local access hit memory");
    a_reserved_quick: assert property (s_take
        ##0 int'(sel_port_in) >= NUM_PORTS
        |-> ##2 done_out && !mem_req_out && !ext_req_out)
        else $error("absent port not local");
    a_ext_route: assert property (s_ext
        |-> ##2 ext_req_out && ext_port_out == $past(sel_port_in, 2)
        && ext_addr_out == $past({sel_bank_in, req_addr_in}, 2))
        else $error("ext port or address wrong");
    a_ext_dir: assert property (s_ext |-> ##2
        ext_write_out == !$past(req_read_not_write_in, 2))
        else $error("ext direction wrong");
    a_pend_nodone: assert property ((mem_req_out || ext_req_out)
        |-> busy_out && !done_out)
        else $error("done while pending");
    a_mem_finish: assert property (mem_req_out && mem_done_in
        |=> !mem_req_out ##1 done_out && !busy_out)
        else $error("mem completion late");
    a_ext_finish: assert property (ext_req_out && ext_done_in
        |=> !ext_req_out && done_out && !busy_out)
        else $error("ext completion late");
    a_done_pulse: assert property (done_out |=> !done_out)
        else $error("done held over a cycle");
endmodule
bind dapsel_top dapsel_props #(.NUM_PORTS(NUM_PORTS), .MEM_PORT(MEM_PORT))
    u_props (.sys_clk_in(sys_clk_in), .arst_n_in(arst_n_in),
    .req_valid_in(req_valid_in), .req_addr_in(req_addr_in),
    .req_read_not_write_in(req_read_not_write_in),
    .sel_port_in(sel_port_in), .sel_bank_in(sel_bank_in),
    .busy_out(busy_out), .done_out(done_out), .mem_req_out(mem_req_out),
    .mem_done_in(mem_done_in), .ext_req_out(ext_req_out),
    .ext_done_in(ext_done_in), .ext_write_out(ext_write_out),
    .ext_port_out(ext_port_out), .ext_addr_out(ext_addr_out));
`default_nettype wire

// ===== verif/dapsel_far_side.sv
// Purpose: Downstream responder, used for memory and external ports
// Assumes: Request level held until the cycle after done
// Notes: Answer delay set by lat_in; store of 64 words
`timescale 1ns/100ps
`default_nettype none
module dapsel_far_side (
    input wire logic sys_clk_in,
    input wire logic arst_n_in,
    input wire logic [3:0] lat_in,
    input wire logic req_in,
    input wire logic write_in,
    input wire logic [5:0] idx_in,
    input wire logic [31:0] wdata_in,
    output logic done_out,
    output logic [31:0] rdata_out
);
    // ******
    // Responder
    // ******
    logic [31:0] store_q [64];
    logic [3:0] cnt_q;
    logic hit;
    assign hit = req_in && !done_out && cnt_q == lat_in;
    // Slow answers stall the selector for as long as needed
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            cnt_q <= 4'h0;
            done_out <= 1'b0;
            rdata_out <= 32'h0;
            store_q <= '{default: 32'h0};
        end else begin
            done_out <= 1'b0;
            rdata_out <= ~rdata_out; // Stale data inverted every cycle between answers
            if (req_in && !done_out) begin
                cnt_q <= cnt_q + 4'h1;
            end
            if (hit) begin
                cnt_q <= 4'h0;
                done_out <= 1'b1;
                rdata_out <= store_q[idx_in];
                if (write_in) store_q[idx_in] <= wdata_in;
            end
        end
    end
endmodule
`default_nettype wire

// ===== verif/dapsel_tb_top.sv
// Purpose: Self-checking bench driving debug-port requests
// Assumes: Memory port 0, external port 1, two ports present
// Notes: Inputs change on the falling edge
`timescale 1ns/100ps
`default_nettype none
`define TB_CHK(got, exp) begin \
    n_compared++; \
    if ((got) !== (exp)) begin \
        bad_count++; \
        $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp); \
    end \
end
module tb_top;
    // ******
    // Set-up
    // ******
    // Identification words are arbitrary values
    localparam logic [31:0] ID0 = 32'h0C0D_0101, ID1 = 32'h0C0D_0202;
    localparam logic [31:0] CFG = 32'h0000_0001, BASE = 32'h0000_3000;
    logic clk, rst_n, rq_v, rq_rnw, busy, done, m_req, m_wr, m_done;
    logic e_req, e_wr, e_done;
    logic [1:0] rq_a;
    logic [3:0] bank, lat;
    logic [7:0] port, e_port;
    logic [5:0] e_addr;
    logic [31:0] wd, rdata, m_addr, m_wd, m_rd, e_wd, e_rd;
    int bad_count = 0, n_compared = 0, mem_n = 0;
    dapsel_top #(.PORT_IDENTS({ID1, ID0}), .CFG_VALUE(CFG),
        .BASE_ADDR(BASE)) DUT (.sys_clk_in(clk), .arst_n_in(rst_n),
        .req_valid_in(rq_v), .req_read_not_write_in(rq_rnw),
        .req_addr_in(rq_a), .req_wdata_in(wd), .sel_port_in(port),
        .sel_bank_in(bank), .busy_out(busy), .done_out(done),
        .rdata_out(rdata), .mem_req_out(m_req), .mem_write_out(m_wr),
        .mem_addr_out(m_addr), .mem_wdata_out(m_wd),
        .mem_done_in(m_done), .mem_rdata_in(m_rd), .ext_req_out(e_req),
        .ext_write_out(e_wr), .ext_port_out(e_port),
        .ext_addr_out(e_addr), .ext_wdata_out(e_wd),
        .ext_done_in(e_done), .ext_rdata_in(e_rd));
    dapsel_far_side u_mem (.sys_clk_in(clk), .arst_n_in(rst_n),
        .lat_in(lat), .req_in(m_req), .write_in(m_wr),
        .idx_in(m_addr[7:2]), .wdata_in(m_wd), .done_out(m_done),
        .rdata_out(m_rd));
    dapsel_far_side u_ext (.sys_clk_in(clk), .arst_n_in(rst_n),
        .lat_in(lat), .req_in(e_req), .write_in(e_wr), .idx_in(e_addr),
        .wdata_in(e_wd), .done_out(e_done), .rdata_out(e_rd));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // Memory transfers seen, to prove local accesses make none
    always @(posedge clk) if (m_done) mem_n++;
    task automatic close_out();
        $display("Compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // One access, then its cycles from acceptance to done
    task automatic acc(input logic read_not_write, input logic [7:0] p,
        input logic [7:0] off, input logic [31:0] d, input int lc);
        int cyc;
        {rq_v, rq_rnw, port, bank, rq_a, wd} = {1'b1, read_not_write, p, off[7:2], d};
        @(negedge clk);
        rq_v = 1'b0;
        cyc = 1;
        while (done !== 1'b1 && cyc < 200) begin
            @(negedge clk);
            cyc++;
        end
        if (cyc >= 200) begin
            bad_count++;
            close_out();
        end
        `TB_CHK(cyc, lc)
    endtask
    task automatic rd(input logic [7:0] p, input logic [7:0] off,
        input logic [31:0] exp, input int lc);
        acc(1'b1, p, off, 32'h0000_0000, lc);
        `TB_CHK(rdata, exp)
    endtask
    task automatic wr(input logic [7:0] p, input logic [7:0] off,
        input logic [31:0] d, input int lc);
        acc(1'b0, p, off, d, lc);
    endtask
    // ******
    // Sequence
    // ******
    initial begin
        {rst_n, rq_v, rq_rnw, rq_a, wd, port, bank, lat} = '0;
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        // Identify every port before using it
        rd(8'h00, 8'hFC, ID0, 2);
        rd(8'h01, 8'hFC, ID1, 2);
        rd(8'h07, 8'hFC, 32'h0000_0000, 2);
        wr(8'h00, 8'hFC, 32'hFFFF_FFFF, 2);
        rd(8'h00, 8'hFC, ID0, 2);
        wr(8'h00, 8'hF4, 32'hFFFF_FFFF, 2);
        rd(8'h00, 8'hF4, CFG, 2);
        rd(8'h00, 8'hF8, BASE, 2);
        // Local registers answer at once with no memory traffic
        wr(8'h00, 8'h00, 32'hA5A5_0F0F, 2);
        rd(8'h00, 8'h00, 32'hA5A5_0F0F, 2);
        wr(8'h00, 8'h04, 32'h0000_0040, 2);
        rd(8'h00, 8'h04, 32'h0000_0040, 2);
        `TB_CHK(mem_n, 0)
        // Slow memory: done only after the far side answers
        lat = 4'h3;
        wr(8'h00, 8'h0C, 32'hDEAD_BEEF, 9);
        rd(8'h00, 8'h0C, 32'hDEAD_BEEF, 9);
        rd(8'h00, 8'h10, 32'hDEAD_BEEF, 9);
        wr(8'h00, 8'h18, 32'h1234_5678, 9);
        wr(8'h00, 8'h04, 32'h0000_0048, 2);
        rd(8'h00, 8'h0C, 32'h1234_5678, 9);
        `TB_CHK(mem_n, 5)
        // Reserved places read zero and drop writes
        wr(8'h00, 8'h24, 32'hFFFF_FFFF, 2);
        rd(8'h00, 8'h24, 32'h0000_0000, 2);
        wr(8'h05, 8'h00, 32'hFFFF_FFFF, 2);
        rd(8'h05, 8'h00, 32'h0000_0000, 2);
        // External port, prompt then stalled
        lat = 4'h0;
        wr(8'h01, 8'h38, 32'h0BAD_F00D, 4);
        rd(8'h01, 8'h38, 32'h0BAD_F00D, 4);
        rd(8'h01, 8'h34, 32'h0000_0000, 4);
        lat = 4'h2;
        rd(8'h01, 8'h38, 32'h0BAD_F00D, 6);
        close_out();
    end
endmodule
`default_nettype wire
